// >>> hdl/pme_wake_map.svh
`ifndef PME_WAKE_MAP_SVH
`define PME_WAKE_MAP_SVH

// register indices; byte address is four times the index
`define IDX_GLOBAL_STS   6'h00
`define IDX_RSVD_AFTER_S 6'h01
`define IDX_GLOBAL_EN    6'h02
`define IDX_RSVD_AFTER_E 6'h03
`define IDX_SRC_PERIPH   6'h04
`define IDX_SRC_PINS_A   6'h05
`define IDX_SRC_PINS_B   6'h06
`define IDX_EN_PERIPH    6'h0A
`define IDX_EN_PINS_A    6'h0B
`define IDX_EN_PINS_B    6'h0C
`define IDX_IRQ_STS      6'h10
`define IDX_IRQ_MASK     6'h11
`define IDX_LINE_LEVEL   6'h12

// field positions
`define FLAG_BIT         0
`define GEN_BIT          0
`define SMI_BIT          3
`define IRQ_WAKE_BIT     0
`define IRQ_SRC_BIT      1

// reset values
`define RST_BYTE         8'h00
`define RST_IRQ          2'h0

`endif

// >>> hdl/pme_wake_pkg.sv
package pme_wake_pkg;
	// one byte-wide register
	typedef logic [7:0] byte_reg_t;
	// word index taken from the bus address
	typedef logic [5:0] reg_idx_t;
	// interrupt status and mask layout
	typedef logic [1:0] irq_vec_t;
endpackage

// >>> hdl/pme_wake_status_enable.sv
// Design decision made here: the APB interface to the registers.
`include "pme_wake_map.svh"

module pme_wake_status_enable
	import pme_wake_pkg::*;
(
	// clock, standby power-on reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// peripheral wake sources, level high
	input  wire logic        i_ring_indicator_second,
	input  wire logic        i_ring_indicator_first,
	input  wire logic        i_keyboard_wake,
	input  wire logic        i_mouse_wake,
	input  wire logic        i_specific_key_wake,
	input  wire logic        i_fan_speed_sense_one,
	input  wire logic        i_fan_speed_sense_two,
	// general purpose wake pins
	input  wire logic [7:0]  i_pin_group1,
	input  wire logic [2:0]  i_pin_group2_lo,
	input  wire logic        i_group_smi_status,
	input  wire logic [7:4]  i_pin_group2_hi,
	// open-drain wake line
	input  wire logic        i_wake_output_n,
	output logic             o_wake_output_n,
	output logic             o_wake_output_n_oe,
	// interrupt
	output logic             o_irq
);

	localparam int NSRC = 25; // 24 source bits plus wake line

	// raw external levels, bit 0 of periph unused
	logic [NSRC-1:0] raw;
	// three-stage synchroniser chain
	logic [NSRC-1:0] sync1;
	logic [NSRC-1:0] sync2;
	logic [NSRC-1:0] sync3;
	// agreed level after filtering
	logic [NSRC-1:0] level;
	// one-cycle rising event per bit
	logic [NSRC-1:0] rise;

	// map pins onto status bit positions
	assign raw = {i_wake_output_n,
		i_pin_group2_hi, i_group_smi_status, i_pin_group2_lo,
		i_pin_group1,
		i_fan_speed_sense_two, i_fan_speed_sense_one,
		i_specific_key_wake, i_mouse_wake, i_keyboard_wake,
		i_ring_indicator_first, i_ring_indicator_second,
		1'b0};

	// synchroniser and agreement filter per bit
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : gen_sync
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
					level[g] <= 1'b0;
				end else if (i_ce) begin
					sync1[g] <= raw[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					// a change counts once stages two and three agree
					if (sync2[g] == sync3[g]) begin
						level[g] <= sync3[g];
					end
				end
			end
			// new high level is the wake event
			assign rise[g] = (sync2[g] == sync3[g]) && sync3[g] && !level[g];
		end
	endgenerate

	// per-register event vectors
	byte_reg_t ev_periph;
	byte_reg_t ev_pins_a;
	byte_reg_t ev_pins_b;
	assign ev_periph = {rise[7:1], 1'b0};
	assign ev_pins_a = rise[15:8];
	assign ev_pins_b = rise[23:16];

	// bus decode
	reg_idx_t  idx;        // word index
	logic      acc_done;   // edge where transfer completes
	logic      mapped;     // index is a known register
	logic      addr_ok;    // aligned and mapped
	logic      wr;         // write takes effect now
	byte_reg_t wbyte;      // write data low byte
	byte_reg_t rbyte;      // read data for current index

	assign idx      = i_paddr[7:2];
	assign acc_done = i_psel && i_penable && o_pready;
	assign addr_ok  = (i_paddr[1:0] == 2'h0) && mapped;
	assign wr       = acc_done && i_pwrite && addr_ok;
	assign wbyte    = i_pwdata[7:0];

	// registers
	logic      flag;          // global wake flag
	logic      gen;           // global wake enable bit
	byte_reg_t sts_periph;    // wake_source_status_periph
	byte_reg_t sts_pins_a;    // wake_source_status_pins_a
	byte_reg_t sts_pins_b;    // wake_source_status_pins_b
	byte_reg_t en_periph;     // per-source enables
	byte_reg_t en_pins_a;
	byte_reg_t en_pins_b;
	irq_vec_t  irq_sts;       // sticky interrupt causes
	irq_vec_t  irq_mask;      // interrupt mask
	logic      pend_d;        // pending as seen last cycle

	// any enabled source with status set
	logic pending;
	logic pend_rise;
	assign pending = |((sts_periph & en_periph) |
		(sts_pins_a & en_pins_a) | (sts_pins_b & en_pins_b));
	assign pend_rise = pending && !pend_d;

	// per-register write hits
	logic hit_flag;
	logic hit_periph;
	logic hit_pins_a;
	logic hit_pins_b;
	logic hit_irq;
	assign hit_flag   = wr && (idx == `IDX_GLOBAL_STS);
	assign hit_periph = wr && (idx == `IDX_SRC_PERIPH);
	assign hit_pins_a = wr && (idx == `IDX_SRC_PINS_A);
	assign hit_pins_b = wr && (idx == `IDX_SRC_PINS_B);
	assign hit_irq    = wr && (idx == `IDX_IRQ_STS);

	// read mux; reserved and unused bits read zero
	always_comb begin
		rbyte  = `RST_BYTE;
		mapped = 1'b1;
		case (idx)
			`IDX_GLOBAL_STS:   rbyte = {7'h00, flag};
			`IDX_RSVD_AFTER_S: rbyte = `RST_BYTE;
			`IDX_GLOBAL_EN:    rbyte = {7'h00, gen};
			`IDX_RSVD_AFTER_E: rbyte = `RST_BYTE;
			`IDX_SRC_PERIPH:   rbyte = sts_periph;
			`IDX_SRC_PINS_A:   rbyte = sts_pins_a;
			`IDX_SRC_PINS_B:   rbyte = sts_pins_b;
			`IDX_EN_PERIPH:    rbyte = en_periph;
			`IDX_EN_PINS_A:    rbyte = en_pins_a;
			`IDX_EN_PINS_B:    rbyte = en_pins_b;
			`IDX_IRQ_STS:      rbyte = {6'h00, irq_sts};
			`IDX_IRQ_MASK:     rbyte = {6'h00, irq_mask};
			`IDX_LINE_LEVEL:   rbyte = {7'h00, level[NSRC-1]};
			default: begin
				// unmapped: error answer, zero data
				mapped = 1'b0;
			end
		endcase
	end

	// apb answer: one wait state, data and error registered
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else if (i_ce) begin
			// ready only for one cycle per access phase
			o_pready <= i_psel && i_penable && !o_pready;
			if (i_psel && i_penable && !o_pready) begin
				o_pslverr <= !addr_ok;
				o_prdata  <= (!i_pwrite && addr_ok) ?
					{24'h00_0000, rbyte} : 32'h0000_0000;
			end else begin
				o_pslverr <= 1'b0;
			end
		end
	end

	// global wake flag: reset only by standby power-on reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag   <= 1'b0;
			pend_d <= 1'b0;
		end else if (i_ce) begin
			pend_d <= pending;
			// set on new need; enable is not looked at
			// edge-based so a clear sticks while sources stay set
			if (pend_rise) begin
				flag <= 1'b1;
			end else if (hit_flag && wbyte[`FLAG_BIT]) begin
				flag <= 1'b0;
			end
			// zero written: no branch taken, flag holds
		end
	end

	// global enable and per-source enables
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gen       <= 1'b0;
			en_periph <= `RST_BYTE;
			en_pins_a <= `RST_BYTE;
			en_pins_b <= `RST_BYTE;
		end else if (i_ce && wr) begin
			case (idx)
				`IDX_GLOBAL_EN: gen       <= wbyte[`GEN_BIT];
				`IDX_EN_PERIPH: en_periph <= {wbyte[7:1], 1'b0};
				`IDX_EN_PINS_A: en_pins_a <= wbyte;
				`IDX_EN_PINS_B: en_pins_b <= wbyte;
				default: begin
					// reserved and status words: nothing here
				end
			endcase
		end
	end

	// source status: set by event, cleared by writing one
	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sts_periph <= `RST_BYTE;
			sts_pins_a <= `RST_BYTE;
			sts_pins_b <= `RST_BYTE;
		end else if (i_ce) begin
			// events land whatever the enables say
			sts_periph <= (sts_periph & ~(hit_periph ? wbyte : 8'h00)) |
				ev_periph;
			sts_pins_a <= (sts_pins_a & ~(hit_pins_a ? wbyte : 8'h00)) |
				ev_pins_a;
			sts_pins_b <= (sts_pins_b & ~(hit_pins_b ? wbyte : 8'h00)) |
				ev_pins_b;
		end
	end

	// wake line: open drain, pulled low while enabled flag stands
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wake_output_n    <= 1'b0;
			o_wake_output_n_oe <= 1'b0;
		end else if (i_ce) begin
			// value is always low; only the enable moves
			o_wake_output_n    <= 1'b0;
			o_wake_output_n_oe <= flag && gen;
		end
	end

	// interrupt causes: wake flag raised, any source event
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_sts  <= `RST_IRQ;
			irq_mask <= `RST_IRQ;
			o_irq    <= 1'b0;
		end else if (i_ce) begin
			irq_sts[`IRQ_WAKE_BIT] <= pend_rise ||
				(irq_sts[`IRQ_WAKE_BIT] && !(hit_irq && wbyte[`IRQ_WAKE_BIT]));
			irq_sts[`IRQ_SRC_BIT] <= (|rise[23:1]) ||
				(irq_sts[`IRQ_SRC_BIT] && !(hit_irq && wbyte[`IRQ_SRC_BIT]));
			if (wr && (idx == `IDX_IRQ_MASK)) begin
				irq_mask <= wbyte[1:0];
			end
			// level output, one cycle behind the status
			o_irq <= |(irq_sts & irq_mask);
		end
	end

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_flag_on_need: assert property (i_ce && pend_rise |=> flag)
		else $error("wake flag not set on new need");

	a_flag_w1c: assert property (
		i_ce && hit_flag && wbyte[0] && !pend_rise |=> !flag)
		else $error("wake flag not cleared by one");

	a_flag_w0_hold: assert property (
		i_ce && hit_flag && !wbyte[0] && !pend_rise
		|=> flag == $past(flag))
		else $error("wake flag changed on zero write");

	a_wake_gated_off: assert property (
		i_ce && !gen |=> !o_wake_output_n_oe)
		else $error("wake driven while disabled");

	a_wake_drive_all: assert property (
		i_ce && flag && gen
		|=> o_wake_output_n_oe && !o_wake_output_n)
		else $error("wake not driven when armed");

	a_rsvd_read_zero: assert property (
		i_ce && i_psel && i_penable && !o_pready && !i_pwrite &&
		(i_paddr == 8'h04 || i_paddr == 8'h0C)
		|=> o_pready && o_prdata == 32'h0000_0000 && !o_pslverr)
		else $error("reserved read not zero");

	a_src_sticky: assert property (
		i_ce && ev_pins_a != 8'h00
		|=> (sts_pins_a & $past(ev_pins_a)) == $past(ev_pins_a))
		else $error("source event lost");

	a_src_w1c_bits: assert property (
		i_ce && hit_pins_a && ev_pins_a == 8'h00
		|=> sts_pins_a == ($past(sts_pins_a) & ~$past(wbyte)))
		else $error("status clear wrong bits");

	a_src_w0_hold: assert property (
		i_ce && hit_pins_b && wbyte == 8'h00 && ev_pins_b == 8'h00
		|=> $stable(sts_pins_b))
		else $error("status changed on zero write");

	a_periph_bit0: assert property (!sts_periph[0])
		else $error("reserved status bit set");

	c_flag_set: cover property (i_ce && pend_rise ##1 flag);
	c_wake_driven: cover property (gen && flag ##1 o_wake_output_n_oe);
	c_wake_released: cover property (
		o_wake_output_n_oe && hit_flag ##[1:3] !o_wake_output_n_oe);
	c_irq_up: cover property (o_irq);

endmodule

// >>> dv/wake_line_host.sv
module wake_line_host (
	// wake line drive from the block
	input  wire logic i_drv,
	input  wire logic i_drv_oe,
	// resolved level of the shared line
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up holds the line high once released; low asks for wake
	assign o_line = i_drv_oe ? i_drv : 1'b1;
endmodule

// >>> dv/test_pme_wake_status_enable.sv
`include "pme_wake_map.svh"

module test_pme_wake_status_enable;
	import pme_wake_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// clock, reset and bus
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// wake sources as vectors
	logic [7:1]  per = 7'h00;
	logic [7:0]  ga = 8'h00;
	logic [7:0]  gb = 8'h00;
	// wake line and interrupt
	logic        drv;
	logic        drv_oe;
	logic        line;
	logic        irq;
	// bookkeeping
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	always #10 i_clk = ~i_clk;

	pme_wake_status_enable u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_ring_indicator_second(per[1]), .i_ring_indicator_first(per[2]),
		.i_keyboard_wake(per[3]), .i_mouse_wake(per[4]),
		.i_specific_key_wake(per[5]), .i_fan_speed_sense_one(per[6]),
		.i_fan_speed_sense_two(per[7]),
		.i_pin_group1(ga), .i_pin_group2_lo(gb[2:0]),
		.i_group_smi_status(gb[3]), .i_pin_group2_hi(gb[7:4]),
		.i_wake_output_n(line), .o_wake_output_n(drv),
		.o_wake_output_n_oe(drv_oe), .o_irq(irq)
	);

	// chipset side of the open-drain wake line
	wake_line_host u_host (.i_drv(drv), .i_drv_oe(drv_oe), .o_line(line));

	// verdict in one place
	task test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard, well above the expected run length
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits for pready under a bound
	task bus(input logic w, input logic [5:0] ix, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [5:0] ix, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		bus(1'b1, ix, {24'h0, d}, r, e);
	endtask

	// read and compare data and error flag
	task rd(input logic [5:0] ix, input logic [7:0] exp, input logic ee = 1'b0);
		logic [31:0] r;
		logic        e;
		bus(1'b0, ix, 32'h0, r, e);
		chk(r, {24'h0, exp});
		chk({31'h0, e}, {31'h0, ee});
	endtask

	// let sync, status, flag and drive settle
	task settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// defaults, reserved offsets, unmapped index
	task t_reset_map();
		for (int i = 0; i < 7; i++) rd(6'(i), 8'h00);
		wr(`IDX_RSVD_AFTER_S, 8'hFF);
		wr(`IDX_RSVD_AFTER_E, 8'hFF);
		rd(`IDX_RSVD_AFTER_S, 8'h00);
		rd(`IDX_RSVD_AFTER_E, 8'h00);
		rd(6'h3F, 8'h00, 1'b1);
	endtask

	// raise each source in turn, no enables set; status is sticky
	task t_walk(input int s, input logic [5:0] ix);
		logic [7:0] m;
		m = 8'h00;
		for (int i = (s == 0); i < 8; i++) begin
			m[i] = 1'b1;
			@(posedge i_clk);
			if (s == 0) per <= m[7:1];
			else if (s == 1) ga <= m;
			else gb <= m;
			settle(8);
			rd(ix, m);
		end
		@(posedge i_clk);
		per <= 7'h00;
		ga <= 8'h00;
		gb <= 8'h00;
		settle(6);
		rd(ix, m);
		chk({31'h0, drv_oe}, 32'h0);
		wr(ix, 8'h00);
		rd(ix, m);
		wr(ix, 8'h08);
		rd(ix, m & 8'hF7);
		wr(ix, 8'hFF);
		rd(ix, 8'h00);
	endtask

	// global flag, enable gating and release of the line
	task t_wake();
		wr(`IDX_EN_PINS_A, 8'h01);
		@(posedge i_clk);
		ga <= 8'h01;
		settle(10);
		rd(`IDX_GLOBAL_STS, 8'h01);
		chk({31'h0, drv_oe}, 32'h0);
		wr(`IDX_GLOBAL_EN, 8'h01);
		settle(3);
		chk({31'h0, drv_oe}, 32'h1);
		chk({31'h0, line}, 32'h0);
		rd(`IDX_LINE_LEVEL, 8'h00);
		wr(`IDX_GLOBAL_STS, 8'h00);
		settle(3);
		rd(`IDX_GLOBAL_STS, 8'h01);
		chk({31'h0, drv_oe}, 32'h1);
		wr(`IDX_GLOBAL_STS, 8'h01);
		settle(3);
		rd(`IDX_GLOBAL_STS, 8'h00);
		chk({31'h0, line}, 32'h1);
		settle(3);
		rd(`IDX_LINE_LEVEL, 8'h01);
		@(posedge i_clk);
		ga <= 8'h03;
		settle(10);
		rd(`IDX_SRC_PINS_A, 8'h03);
		chk({31'h0, drv_oe}, 32'h0);
	endtask

	// interrupt: mask bit high lets a cause through
	task t_irq();
		wr(`IDX_IRQ_MASK, 8'h00);
		settle(3);
		chk({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_MASK, 8'h03);
		settle(3);
		chk({31'h0, irq}, 32'h1);
		wr(`IDX_IRQ_STS, 8'h03);
		settle(3);
		chk({31'h0, irq}, 32'h0);
	endtask

	// a second standby reset clears the enable and status
	task t_rerun_reset();
		@(posedge i_clk);
		i_rst <= 1'b1;
		ga <= 8'h00;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(`IDX_GLOBAL_EN, 8'h00);
		rd(`IDX_SRC_PINS_A, 8'h00);
	endtask

	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset_map();
		t_walk(0, `IDX_SRC_PERIPH);
		t_walk(1, `IDX_SRC_PINS_A);
		t_walk(2, `IDX_SRC_PINS_B);
		t_irq();
		t_wake();
		t_rerun_reset();
		test_done();
	end
endmodule
